// File: rtl/gauge_command_decoder.sv
`timescale 1ns/1ns
module gauge_command_decoder #(
    parameter int unsigned STRETCH_CYCLES = gauge_cmd_pkg::STRETCH_CYCLES
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // Byte transfer port from the link framer
    input  wire logic        xfer_valid_i,
    input  wire logic        xfer_write_i,
    input  wire logic [7:0]  xfer_code_i,
    input  wire logic [7:0]  xfer_wdata_i,
    output logic      [7:0]  xfer_rdata_o,
    output logic             xfer_rvalid_o,
    // Link wake handling
    input  wire logic        link_start_i,
    input  wire logic        link_two_wire_i,
    output logic             osc_stop_o,
    output logic             clock_stretch_o,
    // Power state events
    input  wire logic        doze_enter_i,
    input  wire logic        doze_exit_i,
    // Measurement words
    input  wire logic [7:0]  charge_percent_i,
    input  wire logic [7:0]  error_margin_i,
    input  wire logic [15:0] remaining_capacity_i,
    input  wire logic [15:0] full_capacity_i,
    input  wire logic [15:0] pack_voltage_i,
    input  wire logic [15:0] mean_current_i,
    input  wire logic [15:0] pack_temperature_i,
    input  wire logic [15:0] gauge_status_i,
    input  wire logic [15:0] instant_current_i,
    input  wire logic [15:0] gauge_status_second_i,
    // Gauge condition inputs
    input  wire logic        constant_power_load_i,
    input  wire logic        resistance_update_off_i,
    input  wire logic        voltage_unsuitable_i,
    input  wire logic        checksum_match_i,
    input  wire logic        open_access_i,
    input  wire logic [15:0] counter_offset_meas_i,
    // Control outputs
    output logic             gauging_on_o,
    output logic             full_reset_o,
    output logic             offset_store_o,
    output logic      [15:0] stored_offset_o
);

    logic         locked_r;
    logic         cal_allowed_r;
    logic         cal_mode_r;
    logic         checksum_valid_r;
    logic         deep_doze_flag_r;
    logic         capacity_update_on_r;
    logic         voltage_ok_r;
    logic         load_r;
    logic         res_off_r;
    logic [7:0]   sub_lo_r;
    logic [15:0]  last_sub_r;
    logic [15:0]  result_r;
    logic         show_status_r;
    logic [15:0]  reset_count_r;
    logic [15:0]  counter_offset_r;
    gauge_cmd_pkg::power_state_t pwr_r;
    gauge_cmd_pkg::power_state_t pwr_nxt;

    busy_timer_if board_tif ();
    busy_timer_if cnt_tif ();
    busy_timer_if wake_tif ();

    busy_timer #(.CYCLES(gauge_cmd_pkg::CAL_CYCLES)) u_board_cal (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .tmr       (board_tif)
    );
    busy_timer #(.CYCLES(gauge_cmd_pkg::CAL_CYCLES)) u_cnt_cal (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .tmr       (cnt_tif)
    );
    busy_timer #(.CYCLES(STRETCH_CYCLES)) u_wake (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .tmr       (wake_tif)
    );

    // Transfer decode
    wire        in_deep    = (pwr_r == gauge_cmd_pkg::PWR_DEEP);
    wire        accept     = xfer_valid_i && !in_deep;
    wire        wr_lo      = accept && xfer_write_i
                             && (xfer_code_i == gauge_cmd_pkg::CODE_CONTROL_LO);
    wire        wr_hi      = accept && xfer_write_i
                             && (xfer_code_i == gauge_cmd_pkg::CODE_CONTROL_HI);
    wire        rd_any     = accept && !xfer_write_i;
    wire [15:0] sub_code   = {xfer_wdata_i, sub_lo_r};
    wire        refused    = locked_r && (sub_code >= gauge_cmd_pkg::SUB_LOCKED_MIN);
    wire        exec       = wr_hi && !refused;

    wire do_board_cal  = exec && (sub_code == gauge_cmd_pkg::SUB_BOARD_CAL);
    wire do_cnt_cal    = exec && (sub_code == gauge_cmd_pkg::SUB_CNT_CAL);
    wire do_cnt_store  = exec && (sub_code == gauge_cmd_pkg::SUB_CNT_STORE);
    wire do_deep_arm   = exec && (sub_code == gauge_cmd_pkg::SUB_DEEP_ARM);
    wire do_checksum   = exec && (sub_code == gauge_cmd_pkg::SUB_CHECKSUM);
    wire do_lock       = exec && (sub_code == gauge_cmd_pkg::SUB_LOCK);
    wire do_gauge      = exec && (sub_code == gauge_cmd_pkg::SUB_GAUGE_START);
    wire do_cal_toggle = exec && (sub_code == gauge_cmd_pkg::SUB_CAL_TOGGLE);
    wire do_full_reset = exec && (sub_code == gauge_cmd_pkg::SUB_FULL_RESET);
    wire do_cal_exit   = exec && (sub_code == gauge_cmd_pkg::SUB_CAL_EXIT);
    wire do_cal_enter  = exec && (sub_code == gauge_cmd_pkg::SUB_CAL_ENTER) && cal_allowed_r;
    wire do_offset_rep = exec && (sub_code == gauge_cmd_pkg::SUB_CAL_OFFSET) && cal_mode_r;
    wire wake_event    = in_deep && link_start_i;

    // Control status word; reserved bits tied low
    wire [15:0] status_word;
    assign status_word[15]                               = 1'b0;
    assign status_word[gauge_cmd_pkg::BIT_FULL_LOCK]     = locked_r;
    assign status_word[gauge_cmd_pkg::BIT_LOCKED]        = locked_r;
    assign status_word[gauge_cmd_pkg::BIT_CAL_ALLOWED]   = cal_allowed_r;
    assign status_word[gauge_cmd_pkg::BIT_CNT_CAL]       = cnt_tif.busy;
    assign status_word[gauge_cmd_pkg::BIT_BOARD_CAL]     = board_tif.busy;
    assign status_word[gauge_cmd_pkg::BIT_CHECKSUM]      = checksum_valid_r;
    assign status_word[8:6]                              = 3'h0;
    assign status_word[gauge_cmd_pkg::BIT_DEEP_DOZE]     = deep_doze_flag_r;
    assign status_word[gauge_cmd_pkg::BIT_DOZE]          = (pwr_r != gauge_cmd_pkg::PWR_NORMAL);
    assign status_word[gauge_cmd_pkg::BIT_CONST_POWER]   = load_r;
    assign status_word[gauge_cmd_pkg::BIT_RES_OFF]       = res_off_r;
    assign status_word[gauge_cmd_pkg::BIT_PACK_VOLTAGE_OK]       = voltage_ok_r;
    assign status_word[gauge_cmd_pkg::BIT_CAP_ON]        = capacity_update_on_r;

    // Subcommand result selection
    logic [15:0] result_nxt;
    logic        result_hit;
    always_comb
    begin
        result_hit = 1'b1;
        case (sub_code)
            gauge_cmd_pkg::SUB_PART_TYPE:   result_nxt = gauge_cmd_pkg::PART_TYPE_VAL;
            gauge_cmd_pkg::SUB_FW_REV:      result_nxt = gauge_cmd_pkg::FW_REV_VAL;
            gauge_cmd_pkg::SUB_HW_REV:      result_nxt = gauge_cmd_pkg::HW_REV_VAL;
            gauge_cmd_pkg::SUB_RESET_COUNT: result_nxt = reset_count_r;
            gauge_cmd_pkg::SUB_LAST_SUB:    result_nxt = last_sub_r;
            gauge_cmd_pkg::SUB_CHEM_CODE:   result_nxt = gauge_cmd_pkg::CHEM_CODE_VAL;
            gauge_cmd_pkg::SUB_NVM_REV:     result_nxt = gauge_cmd_pkg::NVM_REV_VAL;
            gauge_cmd_pkg::SUB_CAL_OFFSET:  result_nxt = counter_offset_r;
            default:
            begin
                result_nxt = 16'h0000;
                result_hit = 1'b0;
            end
        endcase
    end

    // Read data: the word index picks the pair, bit 0 picks the byte
    logic [15:0] read_word;
    always_comb
    begin
        case (xfer_code_i[7:1])
            gauge_cmd_pkg::CODE_CONTROL_LO[7:1]:
                read_word = show_status_r ? status_word : result_r;
            gauge_cmd_pkg::CODE_CHARGE[7:1]:    read_word = {error_margin_i, charge_percent_i};
            gauge_cmd_pkg::CODE_REMAINING[7:1]: read_word = remaining_capacity_i;
            gauge_cmd_pkg::CODE_FULL_CAP[7:1]:  read_word = full_capacity_i;
            gauge_cmd_pkg::CODE_VOLTAGE[7:1]:   read_word = pack_voltage_i;
            gauge_cmd_pkg::CODE_MEAN_CUR[7:1]:  read_word = mean_current_i;
            gauge_cmd_pkg::CODE_TEMP[7:1]:      read_word = pack_temperature_i;
            gauge_cmd_pkg::CODE_STATUS[7:1]:    read_word = gauge_status_i;
            gauge_cmd_pkg::CODE_INST_CUR[7:1]:  read_word = instant_current_i;
            gauge_cmd_pkg::CODE_STATUS_B[7:1]:  read_word = gauge_status_second_i;
            default:                            read_word = 16'h0000;
        endcase
    end
    wire [7:0] read_byte = xfer_code_i[0] ? read_word[15:8] : read_word[7:0];

    // Power state
    always_comb
    begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            gauge_cmd_pkg::PWR_NORMAL:
                if (doze_enter_i)
                    pwr_nxt = deep_doze_flag_r ? gauge_cmd_pkg::PWR_DEEP
                                               : gauge_cmd_pkg::PWR_DOZE;
            gauge_cmd_pkg::PWR_DOZE:
                if (doze_exit_i)
                    pwr_nxt = gauge_cmd_pkg::PWR_NORMAL;
                else if (deep_doze_flag_r && doze_enter_i)
                    pwr_nxt = gauge_cmd_pkg::PWR_DEEP;
            gauge_cmd_pkg::PWR_DEEP:
                if (wake_event)
                    pwr_nxt = gauge_cmd_pkg::PWR_DOZE;
            default:
                pwr_nxt = gauge_cmd_pkg::PWR_NORMAL;
        endcase
    end

    assign board_tif.start = do_board_cal;
    assign cnt_tif.start   = do_cnt_cal;
    assign wake_tif.start  = wake_event && link_two_wire_i;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pwr_r <= gauge_cmd_pkg::PWR_NORMAL;
        else
            pwr_r <= pwr_nxt;
    end

    // Access mode and calibration state
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            locked_r      <= gauge_cmd_pkg::RESET_LOCKED;
            cal_allowed_r <= 1'b0;
            cal_mode_r    <= 1'b0;
        end
        else
        begin
            if (do_lock)
                locked_r <= 1'b1;
            else if (open_access_i)
                locked_r <= 1'b0;
            if (do_cal_toggle)
                cal_allowed_r <= !cal_allowed_r;
            if (do_cal_enter)
                cal_mode_r <= 1'b1;
            else if (do_cal_exit || !cal_allowed_r)
                cal_mode_r <= 1'b0;
        end
    end

    // Status flags
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            checksum_valid_r     <= 1'b0;
            deep_doze_flag_r     <= 1'b0;
            capacity_update_on_r <= 1'b0;
            voltage_ok_r         <= 1'b0;
            load_r               <= 1'b0;
            res_off_r            <= 1'b0;
        end
        else
        begin
            load_r    <= constant_power_load_i;
            res_off_r <= resistance_update_off_i;
            if (do_checksum)
                checksum_valid_r <= checksum_match_i;
            if (do_deep_arm)
                deep_doze_flag_r <= 1'b1;
            else if (wake_event)
                deep_doze_flag_r <= 1'b0;
            if (do_gauge)
                capacity_update_on_r <= 1'b1;
            if (do_gauge)
                voltage_ok_r <= 1'b1;
            else if (voltage_unsuitable_i)
                voltage_ok_r <= 1'b0;
        end
    end

    // Subcommand capture and results
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sub_lo_r      <= 8'h00;
            last_sub_r    <= 16'h0000;
            result_r      <= 16'h0000;
            show_status_r <= 1'b1;
            reset_count_r <= 16'h0000;
        end
        else
        begin
            if (wr_lo)
                sub_lo_r <= xfer_wdata_i;
            if (exec && sub_code < gauge_cmd_pkg::SUB_LOCKED_MIN)
                last_sub_r <= sub_code;
            if (exec && (result_hit || sub_code == gauge_cmd_pkg::SUB_STATUS)
                && (do_offset_rep || sub_code != gauge_cmd_pkg::SUB_CAL_OFFSET))
            begin
                show_status_r <= !result_hit;
                result_r      <= result_nxt;
            end
            if (do_full_reset)
                reset_count_r <= reset_count_r + 16'h0001;
        end
    end

    // Counter offset capture and store
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            counter_offset_r <= 16'h0000;
            stored_offset_o  <= 16'h0000;
            offset_store_o   <= 1'b0;
        end
        else
        begin
            if (cnt_tif.done)
                counter_offset_r <= counter_offset_meas_i;
            offset_store_o <= do_cnt_store;
            if (do_cnt_store)
                stored_offset_o <= counter_offset_r;
        end
    end

    // Registered outputs
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            xfer_rdata_o    <= 8'h00;
            xfer_rvalid_o   <= 1'b0;
            osc_stop_o      <= 1'b0;
            clock_stretch_o <= 1'b0;
            gauging_on_o    <= 1'b0;
            full_reset_o    <= 1'b0;
        end
        else
        begin
            xfer_rvalid_o   <= rd_any;
            if (rd_any)
                xfer_rdata_o <= read_byte;
            osc_stop_o      <= (pwr_nxt == gauge_cmd_pkg::PWR_DEEP);
            clock_stretch_o <= wake_tif.start || wake_tif.busy;
            gauging_on_o    <= capacity_update_on_r;
            full_reset_o    <= do_full_reset;
        end
    end

endmodule

// File: rtl/gauge_cmd_pkg.sv
package gauge_cmd_pkg;

    // Standard command codes (byte addresses; CODE_CONTROL_HI and CODE_ERROR name high bytes)
    localparam logic [7:0] CODE_CONTROL_LO  = 8'h00;
    localparam logic [7:0] CODE_CONTROL_HI  = 8'h01;
    localparam logic [7:0] CODE_CHARGE      = 8'h02;
    localparam logic [7:0] CODE_ERROR       = 8'h03;
    localparam logic [7:0] CODE_REMAINING   = 8'h04;
    localparam logic [7:0] CODE_FULL_CAP    = 8'h06;
    localparam logic [7:0] CODE_VOLTAGE     = 8'h08;
    localparam logic [7:0] CODE_MEAN_CUR    = 8'h0A;
    localparam logic [7:0] CODE_TEMP        = 8'h0C;
    localparam logic [7:0] CODE_STATUS      = 8'h0E;
    localparam logic [7:0] CODE_INST_CUR    = 8'h10;
    localparam logic [7:0] CODE_STATUS_B    = 8'h12;
    localparam logic [6:0] WORD_LAST        = 7'h09;

    // Control subcommands
    localparam logic [15:0] SUB_STATUS      = 16'h0000;
    localparam logic [15:0] SUB_PART_TYPE   = 16'h0001;
    localparam logic [15:0] SUB_FW_REV      = 16'h0002;
    localparam logic [15:0] SUB_HW_REV      = 16'h0003;
    localparam logic [15:0] SUB_RESET_COUNT = 16'h0005;
    localparam logic [15:0] SUB_LAST_SUB    = 16'h0007;
    localparam logic [15:0] SUB_CHEM_CODE   = 16'h0008;
    localparam logic [15:0] SUB_BOARD_CAL   = 16'h0009;
    localparam logic [15:0] SUB_CNT_CAL     = 16'h000A;
    localparam logic [15:0] SUB_CNT_STORE   = 16'h000B;
    localparam logic [15:0] SUB_NVM_REV     = 16'h000C;
    localparam logic [15:0] SUB_DEEP_ARM    = 16'h0010;
    localparam logic [15:0] SUB_CHECKSUM    = 16'h0017;
    localparam logic [15:0] SUB_LOCK        = 16'h0020;
    localparam logic [15:0] SUB_GAUGE_START = 16'h0021;
    localparam logic [15:0] SUB_CAL_TOGGLE  = 16'h002D;
    localparam logic [15:0] SUB_FULL_RESET  = 16'h0041;
    localparam logic [15:0] SUB_CAL_EXIT    = 16'h0080;
    localparam logic [15:0] SUB_CAL_ENTER   = 16'h0081;
    localparam logic [15:0] SUB_CAL_OFFSET  = 16'h0082;
    // First code refused while locked, and bound of the last-code report
    localparam logic [15:0] SUB_LOCKED_MIN  = 16'h0020;

    // Control status word bit positions
    localparam int BIT_FULL_LOCK   = 14;
    localparam int BIT_LOCKED      = 13;
    localparam int BIT_CAL_ALLOWED = 12;
    localparam int BIT_CNT_CAL     = 11;
    localparam int BIT_BOARD_CAL   = 10;
    localparam int BIT_CHECKSUM    = 9;
    localparam int BIT_DEEP_DOZE   = 5;
    localparam int BIT_DOZE        = 4;
    localparam int BIT_CONST_POWER = 3;
    localparam int BIT_RES_OFF     = 2;
    localparam int BIT_PACK_VOLTAGE_OK     = 1;
    localparam int BIT_CAP_ON      = 0;

    // Identity values, arbitrary
    localparam logic [15:0] PART_TYPE_VAL = 16'h0A5A;
    localparam logic [15:0] FW_REV_VAL    = 16'h0001;
    localparam logic [15:0] HW_REV_VAL    = 16'h0001;
    localparam logic [15:0] CHEM_CODE_VAL = 16'h0001;
    localparam logic [15:0] NVM_REV_VAL   = 16'h0001;

    // Timing
    localparam int unsigned CLOCK_HZ       = 10_000_000;
    localparam int unsigned STRETCH_MIN_MS = 6;
    localparam int unsigned STRETCH_CYCLES = STRETCH_MIN_MS * (CLOCK_HZ / 1000);
    localparam int unsigned CAL_CYCLES     = 1000;

    localparam logic RESET_LOCKED = 1'b0;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_DOZE,
        PWR_DEEP
    } power_state_t;

endpackage

// File: rtl/busy_timer_if.sv
`timescale 1ns/1ns
interface busy_timer_if;
    logic start;
    logic busy;
    logic done;
    modport timer (input start, output busy, output done);
    modport user  (output start, input busy, input done);
endinterface

// File: rtl/busy_timer.sv
`timescale 1ns/1ns
module busy_timer #(
    parameter int unsigned CYCLES = 1
) (
    input  wire logic    clock_i,
    input  wire logic    sys_rst_i,
    busy_timer_if.timer  tmr
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] cnt_r;
    logic          done_r;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= (cnt_r == ONE);
            if (tmr.start)
                cnt_r <= LOAD;
            else if (cnt_r != '0)
                cnt_r <= cnt_r - ONE;
        end
    end

    assign tmr.busy = (cnt_r != '0);
    assign tmr.done = done_r;
endmodule

// File: verification/gauge_host_model.sv
`timescale 1ns/1ns
module gauge_host_model (
    // Clock
    input  wire logic       clock_i,
    // Byte port
    output logic            valid_o,
    output logic            write_o,
    output logic      [7:0] code_o,
    output logic      [7:0] wdata_o,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    // Wake
    output logic            start_o,
    output logic            two_wire_o
);
    initial {valid_o, write_o, code_o, wdata_o, start_o, two_wire_o} = '0;
    // Released code and data are scrambled, not left at the last value
    task automatic xfer(input logic w, input logic [7:0] c, d, output logic [8:0] q);
        @(posedge clock_i);
        #1;
        {valid_o, write_o, code_o, wdata_o} = {1'b1, w, c, d};
        @(posedge clock_i);
        #1;
        {valid_o, code_o, wdata_o} = {1'b0, ~c, ~d};
        q = {rvalid_i, rdata_i};
    endtask
    task automatic sub(input logic [15:0] s);
        logic [8:0] q;
        xfer(1'b1, 8'h00, s[7:0], q);
        xfer(1'b1, 8'h01, s[15:8], q);
    endtask
    task automatic wake(input logic tw);
        @(posedge clock_i);
        #1;
        {start_o, two_wire_o} = {1'b1, tw};
        @(posedge clock_i);
        #1;
        start_o = 1'b0;
    endtask
endmodule

// File: verification/gauge_cmd_checker.sv
`timescale 1ns/1ns
module gauge_cmd_checker #(
    parameter int unsigned STRETCH_CYCLES = 20
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic xfer_valid_i,
    input wire logic xfer_write_i,
    input wire logic xfer_rvalid_o,
    input wire logic link_start_i,
    input wire logic link_two_wire_i,
    input wire logic osc_stop_o,
    input wire logic clock_stretch_o,
    input wire logic gauging_on_o,
    input wire logic full_reset_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    int unsigned run_r;
    // Length of the current stretch
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            run_r <= 0;
        else
            run_r <= clock_stretch_o ? run_r + 1 : 0;
    end
    sequence wake_two;
        link_start_i && osc_stop_o && link_two_wire_i;
    endsequence
    sequence wake_one;
        link_start_i && osc_stop_o && !link_two_wire_i && !clock_stretch_o;
    endsequence
    AST_RD_ANSWER:
        assert property (xfer_valid_i && !xfer_write_i && !osc_stop_o |=> xfer_rvalid_o)
        else $error("read not answered");
    AST_DEEP_DEAF:
        assert property (xfer_valid_i && osc_stop_o |=> !xfer_rvalid_o)
        else $error("answer in deep doze");
    AST_GAUGE_KEEP:
        assert property (gauging_on_o |=> gauging_on_o)
        else $error("gauging dropped");
    AST_RESET_PULSE:
        assert property (full_reset_o |=> !full_reset_o)
        else $error("reset pulse too long");
    AST_WAKE:
        assert property (link_start_i && osc_stop_o |-> ##[1:2] !osc_stop_o)
        else $error("no wake");
    AST_STRETCH:
        assert property (wake_two |-> ##[1:2] clock_stretch_o [*8])
        else $error("no stretch");
    AST_NO_STRETCH:
        assert property (wake_one |=> !clock_stretch_o [*3])
        else $error("stretch on single wire");
    AST_STRETCH_LEN:
        assert property ($fell(clock_stretch_o) |-> run_r == STRETCH_CYCLES + 1)
        else $error("stretch length");
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        xfer_valid_i, xfer_write_i, link_start_i, link_two_wire_i;
    logic  [7:0] xfer_code_i, xfer_wdata_i, xfer_rdata_o;
    logic        xfer_rvalid_o, osc_stop_o, clock_stretch_o, gauging_on_o, full_reset_o;
    logic        offset_store_o;
    logic [15:0] stored_offset_o;
    logic [15:0] w [0:8];
    logic        doze_enter_i = 1'b0, doze_exit_i = 1'b0, open_access_i = 1'b0;
    logic        constant_power_load_i = 1'b0, resistance_update_off_i = 1'b0;
    logic        voltage_unsuitable_i = 1'b0, checksum_match_i = 1'b0;
    int          err_count = 0;
    int          n_compared = 0;
    always #50 clock_i = ~clock_i;
    gauge_command_decoder #(.STRETCH_CYCLES(20)) dut (
        .clock_i, .sys_rst_i, .xfer_valid_i, .xfer_write_i, .xfer_code_i, .xfer_wdata_i,
        .xfer_rdata_o, .xfer_rvalid_o, .link_start_i, .link_two_wire_i, .osc_stop_o,
        .clock_stretch_o, .doze_enter_i, .doze_exit_i, .charge_percent_i(w[0][7:0]),
        .error_margin_i(w[0][15:8]), .remaining_capacity_i(w[1]), .full_capacity_i(w[2]),
        .pack_voltage_i(w[3]), .mean_current_i(w[4]), .pack_temperature_i(w[5]),
        .gauge_status_i(w[6]), .instant_current_i(w[7]), .gauge_status_second_i(w[8]),
        .constant_power_load_i, .resistance_update_off_i, .voltage_unsuitable_i,
        .checksum_match_i, .open_access_i, .counter_offset_meas_i(w[0]), .gauging_on_o,
        .full_reset_o, .offset_store_o, .stored_offset_o);
    gauge_host_model host (.clock_i, .valid_o(xfer_valid_i), .write_o(xfer_write_i),
        .code_o(xfer_code_i), .wdata_o(xfer_wdata_i), .rdata_i(xfer_rdata_o),
        .rvalid_i(xfer_rvalid_o), .start_o(link_start_i), .two_wire_o(link_two_wire_i));
    task automatic chk(input logic [16:0] got, exp);
        n_compared++;
        if (got !== exp)
            err_count++;
        if (got !== exp)
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    endtask
    // Bit 16 set when both byte reads were answered
    task automatic rdw(input logic [7:0] c, input logic [15:0] e);
        logic [8:0] lo, hi;
        host.xfer(1'b0, c, 8'h00, lo);
        host.xfer(1'b0, c + 8'h01, 8'h00, hi);
        chk({lo[8] & hi[8], hi[7:0], lo[7:0]}, {1'b1, e});
    endtask
    task automatic st(input logic [15:0] e);
        host.sub(16'h0000);
        rdw(8'h00, e);
    endtask
    task automatic pulse(ref logic s);
        @(posedge clock_i);
        #1;
        s = 1'b1;
        @(posedge clock_i);
        #1;
        s = 1'b0;
    endtask
    task automatic t_meas();
        logic [8:0] q;
        for (int p = 0; p < 2; p++)
        begin
            foreach (w[i]) w[i] = {8'(2 * i + 131), 8'(2 * i + 130)} ^ {16{p[0]}};
            for (int c = 2; c < 20; c += 2)
                rdw(8'(c), {8'(c + 129), 8'(c + 128)} ^ {16{p[0]}});
        end
        rdw(8'h14, 16'h0000);
        host.xfer(1'b1, 8'h04, 8'h00, q);
        rdw(8'h04, 16'h7A7B);
    endtask
    task automatic t_status();
        logic [15:0] id [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0008, 16'h000C};
        logic [15:0] v [5] = '{gauge_cmd_pkg::PART_TYPE_VAL, gauge_cmd_pkg::FW_REV_VAL,
            gauge_cmd_pkg::HW_REV_VAL, gauge_cmd_pkg::CHEM_CODE_VAL, gauge_cmd_pkg::NVM_REV_VAL};
        st(16'h0000);
        {constant_power_load_i, resistance_update_off_i} = 2'b11;
        st(16'h000C);
        {constant_power_load_i, resistance_update_off_i} = 2'b00;
        checksum_match_i = 1'b1;
        host.sub(16'h0017);
        checksum_match_i = 1'b0;
        st(16'h0200);
        host.sub(16'h0017);
        st(16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            host.sub(id[i]);
            rdw(8'h00, v[i]);
        end
    endtask
    task automatic t_gauge();
        host.sub(16'h0005);
        host.sub(16'h0021);
        host.sub(16'h0007);
        rdw(8'h00, 16'h0005);
        chk(gauging_on_o, 1'b1);
        st(16'h0003);
        voltage_unsuitable_i = 1'b1;
        st(16'h0001);
    endtask
    task automatic t_cal();
        host.sub(16'h0009);
        st(16'h0401);
        repeat (1000) @(posedge clock_i);
        host.sub(16'h000A);
        st(16'h0801);
        repeat (1000) @(posedge clock_i);
        host.sub(16'h000B);
        chk(offset_store_o, 1'b1);
        st(16'h0001);
        chk(stored_offset_o, w[0]);
        host.sub(16'h002D);
        st(16'h1001);
        host.sub(16'h0081);
        host.sub(16'h0082);
        rdw(8'h00, w[0]);
        host.sub(16'h0080);
        host.sub(16'h0001);
        host.sub(16'h0082);
        rdw(8'h00, gauge_cmd_pkg::PART_TYPE_VAL);
        host.sub(16'h002D);
        st(16'h0001);
    endtask
    task automatic t_lock();
        host.sub(16'h0041);
        chk(full_reset_o, 1'b1);
        host.sub(16'h0005);
        rdw(8'h00, 16'h0001);
        host.sub(16'h0020);
        st(16'h6001);
        host.sub(16'h0041);
        chk(full_reset_o, 1'b0);
        host.sub(16'h0005);
        rdw(8'h00, 16'h0001);
        pulse(open_access_i);
        st(16'h0001);
    endtask
    task automatic t_deep();
        logic [8:0] q;
        for (int tw = 0; tw < 2; tw++)
        begin
            host.sub(16'h0010);
            st(16'h0021);
            pulse(doze_enter_i);
            @(posedge clock_i);
            #1;
            chk(osc_stop_o, 1'b1);
            host.xfer(1'b0, 8'h00, 8'h00, q);
            chk(q[8], 1'b0);
            host.wake(tw[0]);
            @(posedge clock_i);
            #1;
            chk({osc_stop_o, clock_stretch_o}, {1'b0, tw[0]});
            repeat (25) @(posedge clock_i);
            st(16'h0011);
            pulse(doze_exit_i);
            st(16'h0001);
        end
    endtask
    task automatic finish_test();
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clock_i);
        #1;
        sys_rst_i = 1'b0;
        t_meas();
        t_status();
        t_gauge();
        t_cal();
        t_lock();
        t_deep();
        finish_test();
    end
    initial
    begin
        #1_000_000;
        err_count++;
        finish_test();
    end
endmodule
bind gauge_command_decoder gauge_cmd_checker #(.STRETCH_CYCLES(STRETCH_CYCLES)) chk_i (
    .clock_i, .sys_rst_i, .xfer_valid_i, .xfer_write_i, .xfer_rvalid_o, .link_start_i,
    .link_two_wire_i, .osc_stop_o, .clock_stretch_o, .gauging_on_o, .full_reset_o);
